// ==== cedos_crc.sv ====
// crc-15 accumulator over destuffed frame bits
`timescale 1ns/100ps
module cedos_crc (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        shift_i,
    input  wire logic        start_i,
    input  wire logic        bit_i,
    output logic [14:0]      crc_o
);

    logic [14:0] crc_q;
    logic [14:0] base;
    logic        feed;

    // start of frame restarts from zero with the first bit included
    always_comb begin
        base = start_i ? cedos_pkg::RST_CRC : crc_q;
        feed = bit_i ^ base[14];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc_q <= cedos_pkg::RST_CRC;
        end else if (shift_i) begin
            crc_q <= {base[13:0], 1'b0} ^ (feed ? cedos_pkg::CRC_POLY : cedos_pkg::RST_CRC);
        end
    end

    assign crc_o = crc_q;

endmodule

// ==== cedos_node_model.sv ====
// other can node: wired-and bus, dominant wins
`timescale 1ns/100ps
module cedos_node_model (
    input  wire logic own_i,
    input  wire logic drive_i,
    output logic      bus_o
);
    assign bus_o = own_i & drive_i;
endmodule

// ==== cedos_pkg.sv ====
// constants, register map and field codes of the can error detect and object status block
package cedos_pkg;

    // object count and index width
    localparam int            OBJ_N       = 15;
    localparam int            OBJ_IDX_W   = 4;

    // register byte offsets
    localparam logic [7:0]    ADDR_OBJ_SEL     = 8'h00;
    localparam logic [7:0]    ADDR_OBJ_STATUS  = 8'h04;
    localparam logic [7:0]    ADDR_OBJ_LEN     = 8'h08;
    localparam logic [7:0]    ADDR_GEN_STATUS  = 8'h0c;
    localparam logic [7:0]    ADDR_IRQ_STATUS  = 8'h10;
    localparam logic [7:0]    ADDR_IRQ_MASK    = 8'h14;
    localparam logic [7:0]    ADDR_TX_EN       = 8'h18;
    localparam logic [7:0]    ADDR_TX_SEL      = 8'h1c;

    // object_status field positions
    localparam int            BIT_LENGTH_MISMATCH_WARNING = 7;
    localparam int            BIT_TRANSMIT_DONE_FLAG      = 6;
    localparam int            BIT_RECEIVE_DONE_FLAG       = 5;
    localparam int            BIT_BIT_ERROR_FLAG          = 4;
    localparam int            BIT_STUFF_ERROR_FLAG        = 3;
    localparam int            BIT_CRC_ERROR_FLAG          = 2;
    localparam int            BIT_FORM_ERROR_FLAG         = 1;
    localparam int            BIT_ACK_ERROR_FLAG          = 0;
    localparam int            ERR_W                       = 5;

    // protocol counts
    localparam logic [2:0]    STUFF_LIMIT      = 3'h5;
    localparam logic [2:0]    EOF_RX_DONE_IDX  = 3'h5;
    localparam logic [2:0]    EOF_LAST_IDX     = 3'h6;
    localparam int            CRC_W            = 15;
    localparam logic [14:0]   CRC_POLY         = 15'h4599;

    // values after reset
    localparam logic          RST_WAIT         = 1'b1;
    localparam logic          RST_RX_LEVEL     = 1'b1;
    localparam logic [3:0]    RST_OBJ_SEL      = 4'h0;
    localparam logic [14:0]   RST_TX_EN        = 15'h0000;
    localparam logic [15:0]   RST_IRQ_MASK     = 16'h0000;
    localparam logic [15:0]   RST_IRQ_STATUS   = 16'h0000;
    localparam logic [4:0]    RST_GEN_STATUS   = 5'h00;
    localparam logic [14:0]   RST_CRC          = 15'h0000;

    // frame field currently on the bus, given by the protocol engine
    typedef enum logic [3:0] {
        FLD_IDLE,
        FLD_SOF,
        FLD_ARB,
        FLD_CTRL,
        FLD_DATA,
        FLD_CRC,
        FLD_CRC_DELIM,
        FLD_ACK_SLOT,
        FLD_ACK_DELIM,
        FLD_EOF,
        FLD_INTERMISSION,
        FLD_ERR_FLAG,
        FLD_ERR_DELIM,
        FLD_OVL_FLAG,
        FLD_OVL_DELIM
    } cedos_field_type;

endpackage

// ==== cedos_top.sv ====
// error detection and per-object status registers of a can controller
//
// Functional notes
// - Bit error when monitored bus level differs from the level being sent.
// - No bit error for recessive read dominant in arbitration/ack, or dominant in error flag.
// - Stuff error on a sixth identical bit inside the stuffed frame part.
// - Receiver compares crc over destuffed sof..data with the received crc field.
// - Form error on dominant in crc/ack delimiter, end-of-frame (bar a receiver's last bit), error or overload delimiter.
// - Ack error while transmitting when the ack slot stays recessive.
// - Transmit errors go to the status of the sending object.
// - Receive errors go to the matched object, otherwise to the general status.
// - Any detected error requests an error frame.
// - An error flag from another node is detected and answered with our own.
// - Object registers have no reset value; software initialises them.
// - Length mismatch warning on differing dlc; received dlc always overwrites stored dlc.
// - Status flags may interrupt; software clears them by read-modify-write of the register.
// - Transmit done set at the end of the last end-of-frame bit.
// - Lowest enabled object index transmits first.
// - Receive done set at the end of the sixth end-of-frame bit.
// - On several hits the lowest-indexed object is updated.
// - Object bit error flag only for errors while that object transmits.
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module cedos_top #(
    parameter int OBJ_N = cedos_pkg::OBJ_N
) (
    input  wire logic                          CLK_I,
    input  wire logic                          RST_I,
    input  wire logic                          RX_PIN_I,
    input  wire logic                          SAMPLE_I,
    input  wire cedos_pkg::cedos_field_type    FIELD_I,
    input  wire logic                          TX_ACTIVE_I,
    input  wire logic                          TX_BIT_I,
    input  wire logic                          STUFF_BIT_I,
    input  wire logic [3:0]                    RX_DLC_I,
    input  wire logic [OBJ_N-1:0]              HIT_I,
    input  wire logic [7:0]                    ADDRESS_I,
    input  wire logic                          READ_I,
    input  wire logic                          WRITE_I,
    input  wire logic [31:0]                   WRITEDATA_I,
    input  wire logic [3:0]                    BYTEENABLE_I,
    output logic [31:0]                        READDATA_O,
    output logic                               WAITREQUEST_O,
    output logic                               IRQ_O,
    output logic                               ERR_FRAME_O,
    output logic [3:0]                         TX_OBJ_O,
    output logic                               TX_OBJ_VALID_O
);

    localparam int IW = cedos_pkg::OBJ_IDX_W;
    localparam int EW = cedos_pkg::ERR_W;

    // bus pin synchroniser
    logic                rx_meta_q;
    logic                rx_q;

    // protocol tracking
    logic [2:0]          same_cnt_q;
    logic                last_bit_q;
    logic [2:0]          eof_cnt_q;
    logic [14:0]         crc_rx_q;
    logic [14:0]         crc_calc;
    logic                frame_err_q;
    logic                rx_hit_q;
    logic [IW-1:0]       rx_obj_q;
    logic [IW-1:0]       tx_obj_q;
    logic                tx_valid_q;
    logic                err_frame_q;

    // registers
    logic [IW-1:0]       obj_sel_q;
    logic [OBJ_N-1:0]    tx_en_q;
    logic [4:0]          gen_status_q;
    logic [OBJ_N:0]      irq_status_q;
    logic [OBJ_N:0]      irq_mask_q;
    logic                irq_q;
    logic                wait_q;
    logic [31:0]         rdata_q;
    logic [31:0]         rd_mux;

    // per-object views
    logic [7:0]          st_w [OBJ_N];
    logic [3:0]          len_w [OBJ_N];
    logic [OBJ_N-1:0]    obj_event;

    // detection terms
    logic                in_stuffed;
    logic                in_crc_span;
    logic                driving;
    logic                bit_exc;
    logic [EW-1:0]       err_vec;
    logic                any_err;
    logic                tx_done_ev;
    logic                rx_done_ev;
    logic                obj_err_tx;
    logic                obj_err_rx;
    logic                gen_err;

    // bus access terms
    logic                bus_acc;
    logic                bus_wr;
    logic [31:0]         wmask;

    function automatic logic [IW-1:0] lowest(input logic [OBJ_N-1:0] v);
        logic [IW-1:0] r;
        r = '0;
        for (int i = OBJ_N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IW'(i);
            end
        end
        return r;
    endfunction

    // two stages before the sampled bus level is used
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rx_meta_q <= cedos_pkg::RST_RX_LEVEL;
            rx_q      <= cedos_pkg::RST_RX_LEVEL;
        end else begin
            rx_meta_q <= RX_PIN_I;
            rx_q      <= rx_meta_q;
        end
    end

    always_comb begin
        in_crc_span = FIELD_I inside {cedos_pkg::FLD_SOF, cedos_pkg::FLD_ARB,
                                      cedos_pkg::FLD_CTRL, cedos_pkg::FLD_DATA};
        in_stuffed  = in_crc_span || (FIELD_I == cedos_pkg::FLD_CRC);
        driving     = TX_ACTIVE_I || (FIELD_I == cedos_pkg::FLD_ERR_FLAG);
        bit_exc     = ((FIELD_I inside {cedos_pkg::FLD_ARB, cedos_pkg::FLD_ACK_SLOT}) && TX_BIT_I && !rx_q)
                      || ((FIELD_I == cedos_pkg::FLD_ERR_FLAG) && !rx_q);
    end

    always_comb begin
        err_vec = '0;
        err_vec[cedos_pkg::BIT_BIT_ERROR_FLAG] = SAMPLE_I && driving && (rx_q != TX_BIT_I) && !bit_exc;
        // another node's error flag breaks stuffing and shows here too
        err_vec[cedos_pkg::BIT_STUFF_ERROR_FLAG] = SAMPLE_I && in_stuffed && (FIELD_I != cedos_pkg::FLD_SOF)
                                                   && (rx_q == last_bit_q)
                                                   && (same_cnt_q == cedos_pkg::STUFF_LIMIT);
        err_vec[cedos_pkg::BIT_CRC_ERROR_FLAG] = SAMPLE_I && !TX_ACTIVE_I
                                                 && (FIELD_I == cedos_pkg::FLD_CRC_DELIM)
                                                 && (crc_rx_q != crc_calc);
        // last eof bit dominant at a receiver is an overload, not a violation
        err_vec[cedos_pkg::BIT_FORM_ERROR_FLAG] = SAMPLE_I && !rx_q
                                                  && ((FIELD_I inside {cedos_pkg::FLD_CRC_DELIM,
                                                                       cedos_pkg::FLD_ACK_DELIM,
                                                                       cedos_pkg::FLD_ERR_DELIM,
                                                                       cedos_pkg::FLD_OVL_DELIM})
                                                      || ((FIELD_I == cedos_pkg::FLD_EOF)
                                                          && (TX_ACTIVE_I
                                                              || (eof_cnt_q != cedos_pkg::EOF_LAST_IDX))));
        err_vec[cedos_pkg::BIT_ACK_ERROR_FLAG] = SAMPLE_I && TX_ACTIVE_I
                                                 && (FIELD_I == cedos_pkg::FLD_ACK_SLOT) && rx_q;
        any_err = |err_vec;
    end

    // run length of identical bits, stuff bits included
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            same_cnt_q <= 3'h0;
            last_bit_q <= cedos_pkg::RST_RX_LEVEL;
        end else if (SAMPLE_I) begin
            if (FIELD_I == cedos_pkg::FLD_SOF) begin
                same_cnt_q <= 3'h1;
                last_bit_q <= rx_q;
            end else if (in_stuffed) begin
                same_cnt_q <= (rx_q == last_bit_q) ? same_cnt_q + 3'h1 : 3'h1;
                last_bit_q <= rx_q;
            end else begin
                same_cnt_q <= 3'h0;
            end
        end
    end

    cedos_crc u_crc (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .shift_i (SAMPLE_I && in_crc_span && !STUFF_BIT_I),
        .start_i (FIELD_I == cedos_pkg::FLD_SOF),
        .bit_i   (rx_q),
        .crc_o   (crc_calc)
    );

    // destuffed received crc field
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            crc_rx_q <= cedos_pkg::RST_CRC;
        end else if (SAMPLE_I && (FIELD_I == cedos_pkg::FLD_CRC) && !STUFF_BIT_I) begin
            crc_rx_q <= {crc_rx_q[13:0], rx_q};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            eof_cnt_q <= 3'h0;
        end else if (SAMPLE_I) begin
            eof_cnt_q <= (FIELD_I == cedos_pkg::FLD_EOF) ? eof_cnt_q + 3'h1 : 3'h0;
        end
    end

    // any error spoils completion of the current frame
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            frame_err_q <= 1'b0;
        end else begin
            frame_err_q <= any_err || (frame_err_q && !(SAMPLE_I && (FIELD_I == cedos_pkg::FLD_SOF)));
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            err_frame_q <= 1'b0;
        end else begin
            err_frame_q <= any_err;
        end
    end

    // first identifier hit of the frame selects the object
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rx_hit_q <= 1'b0;
            rx_obj_q <= '0;
        end else if (SAMPLE_I && (FIELD_I == cedos_pkg::FLD_SOF)) begin
            rx_hit_q <= 1'b0;
        end else if (!rx_hit_q && (|HIT_I)) begin
            rx_hit_q <= 1'b1;
            rx_obj_q <= lowest(HIT_I);
        end
    end

    // sender choice frozen while a frame is being sent
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tx_valid_q <= 1'b0;
            tx_obj_q   <= '0;
        end else if (!TX_ACTIVE_I) begin
            tx_valid_q <= |tx_en_q;
            tx_obj_q   <= lowest(tx_en_q);
        end
    end

    always_comb begin
        tx_done_ev = SAMPLE_I && TX_ACTIVE_I && tx_valid_q && (FIELD_I == cedos_pkg::FLD_EOF)
                     && (eof_cnt_q == cedos_pkg::EOF_LAST_IDX) && !frame_err_q && !any_err;
        rx_done_ev = SAMPLE_I && !TX_ACTIVE_I && rx_hit_q && (FIELD_I == cedos_pkg::FLD_EOF)
                     && (eof_cnt_q == cedos_pkg::EOF_RX_DONE_IDX) && !frame_err_q && !any_err;
        obj_err_tx = any_err && TX_ACTIVE_I && tx_valid_q;
        obj_err_rx = any_err && !TX_ACTIVE_I && rx_hit_q;
        gen_err    = any_err && !obj_err_tx && !obj_err_rx;
    end

    // avalon slave: one wait cycle, then the accepting edge
    always_comb begin
        bus_acc = READ_I || WRITE_I;
        bus_wr  = WRITE_I && !wait_q;
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{BYTEENABLE_I[b]}};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            wait_q <= cedos_pkg::RST_WAIT;
        end else begin
            wait_q <= !(bus_acc && wait_q);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rdata_q <= 32'h0000_0000;
        end else if (READ_I && wait_q) begin
            rdata_q <= rd_mux;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ADDRESS_I)
            cedos_pkg::ADDR_OBJ_SEL: begin
                rd_mux = 32'(obj_sel_q);
            end
            cedos_pkg::ADDR_OBJ_STATUS: begin
                if (32'(obj_sel_q) < OBJ_N) begin
                    rd_mux = 32'(st_w[obj_sel_q]);
                end
            end
            cedos_pkg::ADDR_OBJ_LEN: begin
                if (32'(obj_sel_q) < OBJ_N) begin
                    rd_mux = 32'(len_w[obj_sel_q]);
                end
            end
            cedos_pkg::ADDR_GEN_STATUS: begin
                rd_mux = 32'(gen_status_q);
            end
            cedos_pkg::ADDR_IRQ_STATUS: begin
                rd_mux = 32'(irq_status_q);
            end
            cedos_pkg::ADDR_IRQ_MASK: begin
                rd_mux = 32'(irq_mask_q);
            end
            cedos_pkg::ADDR_TX_EN: begin
                rd_mux = 32'(tx_en_q);
            end
            cedos_pkg::ADDR_TX_SEL: begin
                rd_mux = 32'({tx_valid_q, tx_obj_q});
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            obj_sel_q <= cedos_pkg::RST_OBJ_SEL;
        end else if (bus_wr && (ADDRESS_I == cedos_pkg::ADDR_OBJ_SEL) && BYTEENABLE_I[0]) begin
            obj_sel_q <= WRITEDATA_I[IW-1:0];
        end
    end

    // software sets producers; a finished transmission retires its object
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tx_en_q <= cedos_pkg::RST_TX_EN;
        end else begin
            tx_en_q <= (bus_wr && (ADDRESS_I == cedos_pkg::ADDR_TX_EN))
                       ? ((tx_en_q & ~wmask[OBJ_N-1:0]) | (WRITEDATA_I[OBJ_N-1:0] & wmask[OBJ_N-1:0]))
                       & ~(tx_done_ev ? (OBJ_N'(1) << tx_obj_q) : '0)
                       : tx_en_q & ~(tx_done_ev ? (OBJ_N'(1) << tx_obj_q) : '0);
        end
    end

    // general status: write one to clear, new error wins
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            gen_status_q <= cedos_pkg::RST_GEN_STATUS;
        end else begin
            gen_status_q <= (gen_status_q
                             & ~((bus_wr && (ADDRESS_I == cedos_pkg::ADDR_GEN_STATUS))
                                 ? (WRITEDATA_I[EW-1:0] & wmask[EW-1:0]) : '0))
                            | (gen_err ? err_vec : '0);
        end
    end

    generate
        for (genvar i = 0; i < OBJ_N; i++) begin : g_obj
            logic [7:0] st_q;
            logic [3:0] len_q;
            logic [7:0] set_v;
            logic       sel;
            logic       rx_me;

            always_comb begin
                sel   = (obj_sel_q == IW'(i));
                rx_me = rx_done_ev && (rx_obj_q == IW'(i));
                set_v = 8'h00;
                set_v[cedos_pkg::BIT_LENGTH_MISMATCH_WARNING] = rx_me && (RX_DLC_I != len_q);
                set_v[cedos_pkg::BIT_TRANSMIT_DONE_FLAG]      = tx_done_ev && (tx_obj_q == IW'(i));
                set_v[cedos_pkg::BIT_RECEIVE_DONE_FLAG]       = rx_me;
                if (obj_err_tx && (tx_obj_q == IW'(i))) begin
                    set_v[EW-1:0] = err_vec;
                end
                if (obj_err_rx && (rx_obj_q == IW'(i))) begin
                    set_v[EW-1:0] = err_vec & ~(EW'(1) << cedos_pkg::BIT_BIT_ERROR_FLAG);
                end
            end

            // no reset: contents are undefined until software writes them
            always_ff @(posedge CLK_I) begin
                if (bus_wr && sel && (ADDRESS_I == cedos_pkg::ADDR_OBJ_STATUS) && BYTEENABLE_I[0]) begin
                    st_q <= WRITEDATA_I[7:0] | set_v;
                end else begin
                    st_q <= st_q | set_v;
                end
            end

            always_ff @(posedge CLK_I) begin
                if (rx_me) begin
                    len_q <= RX_DLC_I;
                end else if (bus_wr && sel && (ADDRESS_I == cedos_pkg::ADDR_OBJ_LEN) && BYTEENABLE_I[0]) begin
                    len_q <= WRITEDATA_I[3:0];
                end
            end

            assign st_w[i]      = st_q;
            assign len_w[i]     = len_q;
            assign obj_event[i] = |set_v;
        end
    endgenerate

    // interrupt status: write one to clear, new event wins
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_status_q <= cedos_pkg::RST_IRQ_STATUS[OBJ_N:0];
        end else begin
            irq_status_q <= (irq_status_q
                             & ~((bus_wr && (ADDRESS_I == cedos_pkg::ADDR_IRQ_STATUS))
                                 ? (WRITEDATA_I[OBJ_N:0] & wmask[OBJ_N:0]) : '0))
                            | {gen_err, obj_event};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_mask_q <= cedos_pkg::RST_IRQ_MASK[OBJ_N:0];
        end else if (bus_wr && (ADDRESS_I == cedos_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_q <= (irq_mask_q & ~wmask[OBJ_N:0]) | (WRITEDATA_I[OBJ_N:0] & wmask[OBJ_N:0]);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    assign READDATA_O     = rdata_q;
    assign WAITREQUEST_O  = wait_q;
    assign IRQ_O          = irq_q;
    assign ERR_FRAME_O    = err_frame_q;
    assign TX_OBJ_O       = tx_obj_q;
    assign TX_OBJ_VALID_O = tx_valid_q;

endmodule

// ==== cedos_top_sva.sv ====
// port checker of the block
`timescale 1ns/100ps
module cedos_top_chk (
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire logic       RX_PIN_I,
    input  wire logic       SAMPLE_I,
    input  wire logic [3:0] FIELD_I,
    input  wire logic       TX_ACTIVE_I,
    input  wire logic       TX_BIT_I,
    input  wire logic       READ_I,
    input  wire logic       WRITE_I,
    input  wire logic       WAITREQUEST_O,
    input  wire logic       ERR_FRAME_O,
    input  wire logic [3:0] TX_OBJ_O,
    input  wire logic       TX_OBJ_VALID_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_dom; !$past(RX_PIN_I, 2) && !$past(RX_PIN_I, 3); endsequence
    sequence s_rec; $past(RX_PIN_I, 2) && $past(RX_PIN_I, 3); endsequence
    sequence s_one_wait; !WAITREQUEST_O ##1 WAITREQUEST_O; endsequence
    property p_wait; (READ_I || WRITE_I) && WAITREQUEST_O |=> s_one_wait; endproperty
    property p_idle; !READ_I && !WRITE_I && !$past(READ_I) && !$past(WRITE_I) |-> WAITREQUEST_O; endproperty
    property p_cause; ERR_FRAME_O |-> $past(SAMPLE_I) ##1 !ERR_FRAME_O; endproperty
    property p_bit; (SAMPLE_I && TX_ACTIVE_I && TX_BIT_I && FIELD_I == cedos_pkg::FLD_DATA) ##0 s_dom
        |=> ERR_FRAME_O; endproperty
    property p_ack_ok; (SAMPLE_I && TX_ACTIVE_I && TX_BIT_I && FIELD_I == cedos_pkg::FLD_ACK_SLOT) ##0 s_dom
        |=> !ERR_FRAME_O; endproperty
    property p_ack_err; (SAMPLE_I && TX_ACTIVE_I && FIELD_I == cedos_pkg::FLD_ACK_SLOT) ##0 s_rec
        |=> ERR_FRAME_O; endproperty
    property p_delim; (SAMPLE_I && TX_ACTIVE_I && FIELD_I == cedos_pkg::FLD_CRC_DELIM) ##0 s_rec
        |=> !ERR_FRAME_O; endproperty
    property p_freeze; $past(TX_ACTIVE_I) |-> $stable(TX_OBJ_O) && $stable(TX_OBJ_VALID_O); endproperty
    a_wait: assert property (p_wait) else $error("wait state");
    a_idle: assert property (p_idle) else $error("idle wait");
    a_cause: assert property (p_cause) else $error("error frame cause");
    a_bit: assert property (p_bit) else $error("bit error missed");
    a_ack_ok: assert property (p_ack_ok) else $error("acked slot error");
    a_ack_err: assert property (p_ack_err) else $error("ack error missed");
    a_delim: assert property (p_delim) else $error("delimiter error");
    a_freeze: assert property (p_freeze) else $error("tx object moved");
endmodule
bind cedos_top cedos_top_chk cedos_top_chk_inst (.CLK_I, .RST_I, .RX_PIN_I, .SAMPLE_I, .FIELD_I,
    .TX_ACTIVE_I, .TX_BIT_I, .READ_I, .WRITE_I, .WAITREQUEST_O, .ERR_FRAME_O, .TX_OBJ_O, .TX_OBJ_VALID_O);

// ==== tb_cedos_top.sv ====
// self-checking bench of the block
`timescale 1ns/100ps
module tb_cedos_top;
    logic        clk = 0, rst = 1, samp = 0, txa = 0, txb = 1, stf = 0, rd = 0, wr = 0, oth = 1;
    logic        bus, wq, irq, tv, last = 1, nost = 0;
    logic [3:0]  dlc = 4'h0, to, len;
    logic [14:0] hit = 15'h0000, crc;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    int          mismatches = 0, checks = 0, run = 0, fault = 0;
    cedos_pkg::cedos_field_type fld = cedos_pkg::FLD_IDLE;
    always #12.5 clk = ~clk;
    cedos_node_model cedos_node_model_inst (.own_i(txa ? txb : 1'b1), .drive_i(oth), .bus_o(bus));
    cedos_top cedos_top_inst (.CLK_I(clk), .RST_I(rst), .RX_PIN_I(bus), .SAMPLE_I(samp), .FIELD_I(fld),
        .TX_ACTIVE_I(txa), .TX_BIT_I(txb), .STUFF_BIT_I(stf), .RX_DLC_I(dlc), .HIT_I(hit), .ADDRESS_I(adr),
        .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wd), .BYTEENABLE_I(4'hf), .READDATA_O(rdat),
        .WAITREQUEST_O(wq), .IRQ_O(irq), .ERR_FRAME_O(), .TX_OBJ_O(to), .TX_OBJ_VALID_O(tv));
    task automatic conclude();
        if (mismatches == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 20);
        q = rdat;
        wr <= 0;
        rd <= 0;
        @(posedge clk);
        if (n >= 20) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic st(input logic [31:0] e, input logic [31:0] m);
        acc(0, cedos_pkg::ADDR_OBJ_STATUS, 32'h0);
        chk("object status", q & m, e);
        acc(1, cedos_pkg::ADDR_OBJ_STATUS, 32'h0);
        acc(1, cedos_pkg::ADDR_IRQ_STATUS, 32'hffff);
    endtask
    task automatic put(input cedos_pkg::cedos_field_type f, input logic b, input logic s);
        fld <= f;
        txb <= b;
        stf <= s;
        oth <= txa ? !((f == cedos_pkg::FLD_ACK_SLOT && fault != 2) || (f == cedos_pkg::FLD_DATA && fault == 3)) : b;
        run = (b == last) ? run + 1 : 1;
        last = b;
        if (!s && f <= cedos_pkg::FLD_DATA) crc = {crc[13:0], 1'b0} ^ ((b ^ crc[14]) ? cedos_pkg::CRC_POLY : 15'h0);
        repeat (3) @(posedge clk);
        samp <= 1;
        @(posedge clk);
        samp <= 0;
    endtask
    task automatic bt(input cedos_pkg::cedos_field_type f, input logic b);
        if (run == 5 && !nost && f <= cedos_pkg::FLD_CRC) put(f, !last, 1);
        put(f, b, 0);
    endtask
    task automatic frame(input logic t, input int flt, input logic ok);
        fault = flt;
        txa <= t;
        crc = 15'h0;
        run = 0;
        @(posedge clk);
        bt(cedos_pkg::FLD_SOF, 0);
        for (int i = 0; i < 26; i++)
            bt(i < 12 ? cedos_pkg::FLD_ARB : i < 18 ? cedos_pkg::FLD_CTRL : cedos_pkg::FLD_DATA, 1'($urandom) | flt == 3);
        for (int i = 14; i >= 0; i--) bt(cedos_pkg::FLD_CRC, crc[i] ^ (flt == 1 && i == 0));
        bt(cedos_pkg::FLD_CRC_DELIM, 1);
        bt(cedos_pkg::FLD_ACK_SLOT, t);
        bt(cedos_pkg::FLD_ACK_DELIM, 1);
        for (int i = 0; i < 7; i++) begin
            bt(cedos_pkg::FLD_EOF, 1);
            repeat (2) @(posedge clk);
            if (ok) chk("irq", 32'(irq), 32'(i >= (t ? 6 : 5)));
        end
        fld <= cedos_pkg::FLD_INTERMISSION;
        txa <= 0;
        @(posedge clk);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        conclude();
    end
    initial begin
        void'($urandom(54));
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int i = 0; i < 15; i++) begin
            acc(1, cedos_pkg::ADDR_OBJ_SEL, 32'(i));
            acc(1, cedos_pkg::ADDR_OBJ_STATUS, 32'h0);
        end
        acc(1, cedos_pkg::ADDR_IRQ_MASK, 32'h8002);
        acc(1, cedos_pkg::ADDR_TX_EN, 32'h0006);
        acc(0, 8'h40, 32'h0);
        chk("unmapped", q, 32'h0);
        chk("tx object", 32'({tv, to}), 32'h11);
        acc(1, cedos_pkg::ADDR_OBJ_SEL, 32'h1);
        frame(1, 2, 0);
        st(32'h01, 32'hff);
        frame(1, 3, 0);
        st(32'h10, 32'h10);
        frame(1, 0, 1);
        st(32'h40, 32'hff);
        chk("tx object", 32'({tv, to}), 32'h12);
        len = 4'($urandom);
        acc(1, cedos_pkg::ADDR_OBJ_LEN, 32'(len));
        dlc <= ~len;
        hit <= 15'h0006;
        frame(0, 0, 1);
        acc(0, cedos_pkg::ADDR_OBJ_STATUS, 32'h0);
        chk("object status", q, 32'ha0);
        acc(1, cedos_pkg::ADDR_OBJ_STATUS, q & ~32'h20);
        st(32'h80, 32'hff);
        acc(0, cedos_pkg::ADDR_OBJ_LEN, 32'h0);
        chk("object length", q, {28'h0, ~len});
        acc(1, cedos_pkg::ADDR_OBJ_SEL, 32'h2);
        st(32'h00, 32'hff);
        acc(1, cedos_pkg::ADDR_OBJ_SEL, 32'h1);
        frame(0, 1, 0);
        st(32'h04, 32'hff);
        hit <= 15'h0000;
        nost = 1;
        bt(cedos_pkg::FLD_SOF, 0);
        repeat (5) bt(cedos_pkg::FLD_ARB, 0);
        fld <= cedos_pkg::FLD_IDLE;
        acc(0, cedos_pkg::ADDR_GEN_STATUS, 32'h0);
        chk("general status", q, 32'h08);
        conclude();
    end
endmodule
